// *** common/tamper_pkg.sv ***
// Shared constants and types for the access opening tamper monitor
package tamper_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_PANELS = 4;
  localparam int NUM_MODULES = 32;
  localparam int HIST_DEPTH = 16;
  localparam int TIME_W = 32;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int WINDOW_HOURS = 8;
  localparam longint WINDOW_TICKS_L =
    longint'(WINDOW_HOURS) * 3600 * 1000 * 1000 / TICK_PERIOD_US;
  localparam logic [TIME_W-1:0] WINDOW_TICKS = WINDOW_TICKS_L[TIME_W-1:0];
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Removal limit: lesser of 15 and the 5 percent screen count
  // ---------------------------------------------------------------
  localparam int MAX_REMOVALS_ABS = 15;
  localparam int SCREEN_PCT_MODULES = 15;
  localparam int MODULE_REMOVAL_LIMIT =
    (SCREEN_PCT_MODULES < MAX_REMOVALS_ABS) ? SCREEN_PCT_MODULES
                                            : MAX_REMOVALS_ABS;

  // ---------------------------------------------------------------
  // Alarm state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ALARM = 2'b01
  } alarm_state_t;

endpackage

// *** common/tamper_if.sv ***
// Link between the imaging device monitor and the companion media unit
`timescale 1ns/1ps
interface tamper_if;
  logic access_open_event;
  logic access_opened_log_event;
  logic access_closed_log_event;
  logic module_removed;
  logic playback_active;

  modport device (
    output access_open_event,
    output access_opened_log_event,
    output access_closed_log_event,
    output module_removed,
    input playback_active
  );

  modport media (
    input access_open_event,
    input access_opened_log_event,
    input access_closed_log_event,
    input module_removed,
    output playback_active
  );
endinterface

// *** design/access_opening_tamper_monitor.sv ***
// Imaging device end: sensor conditioning, removal window, access alarm
//
// Functional notes
// - Drive access event when opening detected
// - Opening during playback stops playback
// - Refuse playback start while panel open
// - Media unit logs each opening from all panels closed
// - Media unit logs each closure of the last open panel
// - Exposing replacement method asserts access event
// - Playback inhibited while access event asserted
// - One event may cover grouped replacement
// - Detect module removal, inhibit encrypted playback
// - Removals over limit in 8h raise event
// - Clearing alarm keeps removal history
// - Clear alarm only by key or code
`timescale 1ns/1ps
module access_opening_tamper_monitor
  import tamper_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int DEBOUNCE_CYC = DEBOUNCE_CYCLES,
  parameter logic [TIME_W-1:0] WINDOW_LEN = WINDOW_TICKS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NUM_PANELS-1:0] panel_open_raw,
  input wire logic [NUM_MODULES-1:0] module_present_raw,
  input wire logic service_exposed_raw,
  input wire logic key_clear_raw,
  input wire logic code_clear,
  tamper_if.device link,
  output logic alarm_active,
  output logic [4:0] window_count
);

  localparam int NS = NUM_PANELS + NUM_MODULES + 2;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [NS-1:0] raw_in;
  logic [NS-1:0] s1_ff;
  logic [NS-1:0] s2_ff;
  logic [NS-1:0] s3_ff;
  logic [NS-1:0] deb_ff;
  logic [NS-1:0] deb_prev_ff;
  logic [31:0] cnt_ff [NS];

  assign raw_in = {key_clear_raw, service_exposed_raw,
                   ~module_present_raw, panel_open_raw};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ---------------------------------------------------------------
  // Debounce: level must stay stable for DEBOUNCE_CYC cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      deb_ff <= '0;
      deb_prev_ff <= '0;
      for (int i = 0; i < NS; i++)
      begin
        cnt_ff[i] <= '0;
      end
    end
    else
    begin
      deb_prev_ff <= deb_ff;
      for (int i = 0; i < NS; i++)
      begin
        if (s2_ff[i] != s3_ff[i] || s3_ff[i] == deb_ff[i])
        begin
          cnt_ff[i] <= '0;
        end
        else if (cnt_ff[i] >= 32'(DEBOUNCE_CYC - 1))
        begin
          cnt_ff[i] <= '0;
          deb_ff[i] <= s3_ff[i];
        end
        else
        begin
          cnt_ff[i] <= cnt_ff[i] + 32'd1;
        end
      end
    end
  end

  logic [NUM_PANELS-1:0] panel_open;
  logic [NUM_MODULES-1:0] mod_out;
  logic [NUM_MODULES-1:0] mod_rise;
  logic any_open;
  logic any_open_prev;
  logic exposed;
  logic exposed_rise;
  logic key_rise;
  logic removal_evt;

  assign panel_open = deb_ff[NUM_PANELS-1:0];
  assign mod_out = deb_ff[NUM_PANELS +: NUM_MODULES];
  assign mod_rise = mod_out & ~deb_prev_ff[NUM_PANELS +: NUM_MODULES];
  assign any_open = |panel_open;
  assign any_open_prev = |deb_prev_ff[NUM_PANELS-1:0];
  assign exposed = deb_ff[NS-2];
  assign exposed_rise = exposed & ~deb_prev_ff[NS-2];
  assign key_rise = deb_ff[NS-1] & ~deb_prev_ff[NS-1];
  assign removal_evt = |mod_rise;

  // ---------------------------------------------------------------
  // Time base: one tick per TICK_CYC cycles
  // ---------------------------------------------------------------
  logic [31:0] tdiv_ff;
  logic [TIME_W-1:0] now_ff;
  logic tick;

  assign tick = (tdiv_ff == 32'(TICK_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tdiv_ff <= '0;
      now_ff <= '0;
    end
    else if (tick)
    begin
      tdiv_ff <= '0;
      now_ff <= now_ff + 1'b1;
    end
    else
    begin
      tdiv_ff <= tdiv_ff + 32'd1;
    end
  end

  // ---------------------------------------------------------------
  // Removal history: ring of timestamps, never cleared by alarm reset
  // ---------------------------------------------------------------
  logic [TIME_W-1:0] stamp_ff [HIST_DEPTH];
  logic [HIST_DEPTH-1:0] used_ff;
  logic [3:0] wr_ff;
  logic [4:0] in_win;

  function automatic logic live(input logic u,
                                input logic [TIME_W-1:0] ts,
                                input logic [TIME_W-1:0] now);
    live = u && ((now - ts) < WINDOW_LEN);
  endfunction

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      used_ff <= '0;
      wr_ff <= '0;
    end
    else
    begin
      // Stamps need no reset: an entry counts only while its used bit is set
      for (int i = 0; i < HIST_DEPTH; i++)
      begin
        used_ff[i] <= live(used_ff[i], stamp_ff[i], now_ff);
      end
      if (removal_evt)
      begin
        stamp_ff[wr_ff] <= now_ff;
        used_ff[wr_ff] <= 1'b1;
        wr_ff <= wr_ff + 4'd1;
      end
    end
  end

  always_comb
  begin
    in_win = '0;
    for (int i = 0; i < HIST_DEPTH; i++)
    begin
      in_win = in_win + 5'(live(used_ff[i], stamp_ff[i], now_ff));
    end
  end

  logic limit_hit;

  // A removal above the limit alarms again even after a clear
  assign limit_hit = removal_evt &
                     (in_win >= 5'(MODULE_REMOVAL_LIMIT));

  // ---------------------------------------------------------------
  // Access alarm: held until key or code once sources are gone
  // ---------------------------------------------------------------
  alarm_state_t state_ff;
  logic trigger;
  logic clear_req;

  // A grouped replacement holds exposed high: one rising edge, one event
  assign trigger = (any_open & ~any_open_prev) | exposed_rise |
                   limit_hit;
  assign clear_req = key_rise | code_clear;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (trigger)
          begin
            state_ff <= ST_ALARM;
          end
        end
        ST_ALARM:
        begin
          // Trigger wins over a clear in the same cycle
          if (clear_req && !trigger && !any_open && !exposed)
          begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Link outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      link.access_open_event <= 1'b0;
      link.access_opened_log_event <= 1'b0;
      link.access_closed_log_event <= 1'b0;
      link.module_removed <= 1'b0;
      alarm_active <= 1'b0;
      window_count <= '0;
    end
    else
    begin
      link.access_open_event <= (state_ff == ST_ALARM) | trigger;
      link.access_opened_log_event <= any_open & ~any_open_prev;
      link.access_closed_log_event <= ~any_open & any_open_prev;
      link.module_removed <= |mod_out;
      alarm_active <= (state_ff == ST_ALARM) | trigger;
      window_count <= in_win;
    end
  end

endmodule

// *** design/companion_media_unit.sv ***
// Companion media unit end: playback gating and access log counters
`timescale 1ns/1ps
module companion_media_unit
  import tamper_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  tamper_if.media link,
  input wire logic play_start,
  input wire logic play_stop,
  input wire logic content_encrypted,
  output logic playing,
  output logic play_refused,
  output logic [15:0] opened_log_count,
  output logic [15:0] closed_log_count,
  output logic log_opened_pulse,
  output logic log_closed_pulse
);

  // ---------------------------------------------------------------
  // Playback gating
  // ---------------------------------------------------------------
  logic inhibit;

  assign inhibit = link.access_open_event |
                   (link.module_removed & content_encrypted);
  assign link.playback_active = playing;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      playing <= 1'b0;
      play_refused <= 1'b0;
    end
    else
    begin
      play_refused <= play_start & inhibit;
      if (inhibit || play_stop)
      begin
        playing <= 1'b0;
      end
      else if (play_start)
      begin
        playing <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Log records: one when the first panel opens, one when the last one closes
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      opened_log_count <= '0;
      closed_log_count <= '0;
      log_opened_pulse <= 1'b0;
      log_closed_pulse <= 1'b0;
    end
    else
    begin
      log_opened_pulse <= link.access_opened_log_event;
      log_closed_pulse <= link.access_closed_log_event;
      if (link.access_opened_log_event)
      begin
        opened_log_count <= opened_log_count + 16'h0001;
      end
      if (link.access_closed_log_event)
      begin
        closed_log_count <= closed_log_count + 16'h0001;
      end
    end
  end

endmodule

// *** dv/tamper_link_properties.sv ***
// Checker for the link between the monitor and the media unit
`timescale 1ns/1ps
module tamper_link_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic access_open_event,
  input wire logic access_opened_log_event,
  input wire logic access_closed_log_event,
  input wire logic module_removed,
  input wire logic playback_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  AST_OPEN_LOG_PULSE: assert property (
    access_opened_log_event |=> !access_opened_log_event)
    else $error("opened log pulse longer than one cycle");
  AST_CLOSE_LOG_PULSE: assert property (
    access_closed_log_event |=> !access_closed_log_event)
    else $error("closed log pulse longer than one cycle");
  AST_OPEN_RAISES_EVENT: assert property (
    access_opened_log_event |-> access_open_event)
    else $error("opening seen without access event");
  AST_OPEN_STOPS_PLAY: assert property (
    access_opened_log_event |=> !playback_active)
    else $error("playback kept running after opening");
  AST_NO_START_IN_EVENT: assert property (
    $rose(playback_active) |-> !$past(access_open_event))
    else $error("playback started while access event set");
  AST_EVENT_INHIBITS: assert property (
    access_open_event |=> !playback_active)
    else $error("playback active while access event set");

  // -------------------------------------------------------------
  // Coverage
  // -------------------------------------------------------------
  cover property (access_opened_log_event);
  cover property (access_closed_log_event);
  cover property ($fell(access_open_event));
  cover property ($rose(module_removed));
endmodule

// *** dv/testbench.sv ***
// Self-checking bench joining the monitor and the media unit
`timescale 1ns/1ps
module testbench;
  import tamper_pkg::*;
  localparam int S = 20;
  localparam int WIN_CYC = 1000; // 100 ticks of 10 cycles
  logic clk = 0;
  logic sys_rst = 1;
  logic [3:0] panel_open_raw = '0;
  logic [31:0] module_present_raw = '1;
  logic service_exposed_raw = 0;
  logic key_clear_raw = 0;
  logic code_clear = 0;
  logic play_start = 0;
  logic play_stop = 0;
  logic content_encrypted = 0;
  logic alarm_active, playing, play_refused;
  logic log_opened_pulse, log_closed_pulse;
  logic [4:0] window_count;
  logic [15:0] opened_log_count, closed_log_count;
  int errors = 0;
  int n_checks = 0;
  int n_ref = 0;
  int m_open = 0;
  int m_close = 0;
  int m_ref = 0;
  int m_rem = 0;
  int n_lo = 0;
  int n_lc = 0;
  int rem_q[$];
  int p, r;

  tamper_if lnk ();
  access_opening_tamper_monitor #(.TICK_CYC(10), .DEBOUNCE_CYC(4),
    .WINDOW_LEN(32'h0000_0064)) access_opening_tamper_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .panel_open_raw(panel_open_raw),
    .module_present_raw(module_present_raw),
    .service_exposed_raw(service_exposed_raw),
    .key_clear_raw(key_clear_raw), .code_clear(code_clear),
    .link(lnk.device), .alarm_active(alarm_active),
    .window_count(window_count));
  companion_media_unit companion_media_unit_inst (
    .clk(clk), .sys_rst(sys_rst), .link(lnk.media),
    .play_start(play_start), .play_stop(play_stop),
    .content_encrypted(content_encrypted), .playing(playing),
    .play_refused(play_refused), .opened_log_count(opened_log_count),
    .closed_log_count(closed_log_count),
    .log_opened_pulse(log_opened_pulse),
    .log_closed_pulse(log_closed_pulse));
  tamper_link_properties tamper_link_properties_inst (
    .clk(clk), .sys_rst(sys_rst),
    .access_open_event(lnk.access_open_event),
    .access_opened_log_event(lnk.access_opened_log_event),
    .access_closed_log_event(lnk.access_closed_log_event),
    .module_removed(lnk.module_removed),
    .playback_active(lnk.playback_active));

  initial
  begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (play_refused === 1'b1)
      n_ref++;
    if (log_opened_pulse === 1'b1)
      n_lo++;
    if (log_closed_pulse === 1'b1)
      n_lc++;
  end

  // -------------------------------------------------------------
  // Helper tasks
  // -------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Removals the trailing window still holds, capped at the history depth
  function automatic int win_exp();
    int n;
    n = 0;
    foreach (rem_q[k])
    begin
      if (int'($time / CLK_PERIOD_NS) - rem_q[k] < WIN_CYC)
        n++;
    end
    return (n > HIST_DEPTH) ? HIST_DEPTH : n;
  endfunction

  task automatic start();
    @(posedge clk);
    play_start <= 1'b1;
    @(posedge clk);
    play_start <= 1'b0;
    cyc(2);
  endtask

  task automatic clr_code();
    @(posedge clk);
    code_clear <= 1'b1;
    @(posedge clk);
    code_clear <= 1'b0;
    cyc(3);
  endtask

  task automatic clr_key();
    @(posedge clk);
    key_clear_raw <= 1'b1;
    cyc(S);
    key_clear_raw <= 1'b0;
    cyc(S);
  endtask

  task automatic swap_module(input int i);
    @(posedge clk);
    module_present_raw[i] <= 1'b0;
    rem_q.push_back(int'($time / CLK_PERIOD_NS));
    cyc(S);
    module_present_raw[i] <= 1'b1;
    cyc(S);
    m_rem++;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    errors++;
    wrap_up();
  end

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial
  begin
    void'($urandom(52468));
    cyc(4);
    sys_rst <= 1'b0;
    cyc(1);
    chk("event", lnk.access_open_event, 0);
    p = $urandom % 4;
    for (int i = 0; i < 4; i++)
    begin
      start();
      chk("playing", playing, 1);
      panel_open_raw[(p + i) % 4] <= 1'b1;
      cyc(S);
      m_open++;
      chk("playing", playing, 0);
      chk("event", lnk.access_open_event, 1);
      start();
      m_ref++;
      chk("refused", n_ref, m_ref);
      clr_code();
      chk("alarm", alarm_active, 1);
      panel_open_raw[(p + i) % 4] <= 1'b0;
      cyc(S);
      m_close++;
      chk("opened", opened_log_count, m_open);
      chk("closed", closed_log_count, m_close);
      chk("open_pulses", n_lo, m_open);
      chk("close_pulses", n_lc, m_close);
      if (i % 2 == 1)
        clr_key();
      else
        clr_code();
      chk("event", lnk.access_open_event, 0);
    end
    start();
    service_exposed_raw <= 1'b1;
    cyc(S);
    chk("event", lnk.access_open_event, 1);
    chk("playing", playing, 0);
    service_exposed_raw <= 1'b0;
    cyc(S);
    clr_code();
    chk("event", lnk.access_open_event, 0);
    content_encrypted <= 1'b1;
    start();
    r = $urandom % 32;
    module_present_raw[r] <= 1'b0;
    rem_q.push_back(int'($time / CLK_PERIOD_NS));
    cyc(S);
    chk("removed", lnk.module_removed, 1);
    chk("playing", playing, 0);
    start();
    m_ref++;
    chk("refused", n_ref, m_ref);
    content_encrypted <= 1'b0;
    start();
    chk("playing", playing, 1);
    play_stop <= 1'b1;
    cyc(1);
    play_stop <= 1'b0;
    cyc(2);
    chk("playing", playing, 0);
    module_present_raw[r] <= 1'b1;
    cyc(S);
    m_rem++;
    while (m_rem < MODULE_REMOVAL_LIMIT)
      swap_module($urandom % 32);
    chk("count", window_count, win_exp());
    chk("event", lnk.access_open_event, 0);
    swap_module($urandom % 32);
    chk("event", lnk.access_open_event, 1);
    clr_code();
    chk("event", lnk.access_open_event, 0);
    chk("count", window_count, win_exp());
    swap_module($urandom % 32);
    chk("event", lnk.access_open_event, 1);
    chk("count", window_count, win_exp());
    clr_code();
    chk("event", lnk.access_open_event, 0);
    cyc(1100);
    chk("count", window_count, win_exp());
    wrap_up();
  end
endmodule
